/* File: apcc_pkg.sv */
// Constants and types shared by the audio port clock checker.
// Assumes a 250 MHz system clock; all timings are derived from it.
package apcc_pkg;

  // ==========================================================
  // Clocking and detector limits
  localparam longint SYS_HZ         = 250_000_000;
  localparam longint BCLK_MIN_HZ    = 256_000;
  localparam longint BCLK_MAX_HZ    = 50_000_000;
  localparam longint PLL_MAX_HZ     = 150_000_000;
  localparam longint PLL_MULT       = 4;
  localparam longint RATE_MIN_HZ    = 32_000;
  localparam longint RATE_MAX_HZ    = 192_000;
  localparam int     RATIO_MIN      = 32;
  localparam int     RATIO_MAX      = 512;
  // Longest legal bit clock period rounds down, shortest rounds up
  localparam int BPER_MAX = int'(SYS_HZ / BCLK_MIN_HZ);
  localparam int BPER_MIN = int'((SYS_HZ + BCLK_MAX_HZ - 1) / BCLK_MAX_HZ);
  localparam int BMISS    = 2 * BPER_MAX;
  // PLL at or above its limit when period is this short or shorter
  localparam int PLL_PER  = int'(SYS_HZ * PLL_MULT / PLL_MAX_HZ);
  localparam int FPER_MIN = int'((SYS_HZ + RATE_MAX_HZ - 1) / RATE_MAX_HZ);
  localparam int FPER_MAX = int'(SYS_HZ / RATE_MIN_HZ);

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_MASK   = 8'h29;
  localparam logic [7:0] ADDR_SRC    = 8'h30;
  localparam logic [7:0] ADDR_POL    = 8'h31;
  localparam logic [7:0] ADDR_STATUS = 8'h39;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_SRC     = 8'h00;
  localparam logic [7:0] RST_POL     = 8'h00;
  localparam logic [7:0] POL_RO_MSK  = 8'h0E;
  localparam int BIT_IGN_PLL   = 6;
  localparam int BIT_IGN_RANGE = 5;
  localparam int BIT_IGN_RATE  = 4;
  localparam int BIT_IGN_RATIO = 3;
  localparam int BIT_IGN_MISS  = 2;
  localparam int BIT_OUT_SEL   = 0;
  localparam int BIT_BCLK_POL  = 5;
  // Status bit positions
  localparam int ST_MISS  = 0;
  localparam int ST_RATIO = 1;
  localparam int ST_RATE  = 2;
  localparam int ST_RANGE = 3;
  localparam int ST_PLL   = 4;
  localparam int ST_CLKER = 5;
  localparam int ST_OVF   = 6;

  // ==========================================================
  // Data path
  localparam int WORD_W     = 32;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    APCC_WAIT  = 2'b00,
    APCC_ALIGN = 2'b01,
    APCC_RUN   = 2'b11
  } apcc_state_t;

endpackage

/* File: apcc_fifo.sv */
// Small FIFO with a registered output stage.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
module apcc_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                ov;
    logic [W-1:0]        od;
  } apcc_fifo_st_t;

  apcc_fifo_st_t q, d;
  logic push, load;

  // ==========================================================
  // Storage and output register
  always_comb begin
    d    = q;
    push = i_in_valid && (q.cnt != (AW+1)'(D));
    load = (q.cnt != '0) && (!q.ov || i_out_ready);
    if (push) begin
      d.mem[q.wp] = i_in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (o_out_valid && i_out_ready) begin
      d.ov = 1'b0;
    end
    if (load) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_in_ready  = (q.cnt != (AW+1)'(D));
  assign o_out_valid = q.ov;
  assign o_out_data  = q.od;

  // ==========================================================
  // Checks
  a_fifo_no_overfill: assert property (@(posedge i_clk_sys)
    disable iff (i_srst) q.cnt <= (AW+1)'(D))
    else $error("fifo count above depth");
endmodule

/* File: apcc_top.sv */
// Serial audio port clock supervision, configuration and capture.
// Assumes bit clock, frame clock and data arrive from an outside source
// and registers are written over a simple same-clock register port.
`timescale 1ns/1ps
module apcc_top import apcc_pkg::*; #(
  parameter int P_FPER_MAX = FPER_MAX
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  input  wire logic              i_bit_clock,
  input  wire logic              i_frame_clock,
  input  wire logic              i_serial_data_in,
  input  wire logic              i_post_sdata,
  output logic                   o_serial_data_out,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_clock_error,
  output logic                   o_word_valid,
  input  wire logic              i_word_ready,
  output logic [WORD_W-1:0]      o_word_data
);

  typedef struct packed {
    apcc_state_t       st;
    logic [2:0]        bsy;
    logic [2:0]        fsy;
    logic [1:0]        dsy;
    logic [11:0]       bper;
    logic [12:0]       fper;
    logic [9:0]        ratio;
    logic              fsmp;
    logic [WORD_W-1:0] shreg;
    logic              push;
    logic [WORD_W-1:0] word;
    logic              e_miss;
    logic              e_ratio;
    logic              e_rate;
    logic              e_range;
    logic              e_pll;
    logic              clk_err;
    logic              ovf;
    logic [7:0]        mask;
    logic [7:0]        src;
    logic [7:0]        pol;
    logic [7:0]        rdata;
    logic              sdo;
  } apcc_st_t;

  apcc_st_t q, d;
  logic fifo_ready;

  // ==========================================================
  // Helpers
  function automatic logic combine(input logic [7:0] m,
                                   input logic a, input logic b,
                                   input logic c, input logic e,
                                   input logic f);
    combine = (a && !m[BIT_IGN_MISS])  || (b && !m[BIT_IGN_RATIO]) ||
              (c && !m[BIT_IGN_RATE])  || (e && !m[BIT_IGN_RANGE]) ||
              (f && !m[BIT_IGN_PLL]);
  endfunction

  logic b_rise, b_fall, f_rise, smp;
  logic [11:0] bmeas;
  logic [12:0] fmeas;
  logic [7:0]  status;

  always_comb begin
    b_rise = q.bsy[1] && !q.bsy[2];
    b_fall = !q.bsy[1] && q.bsy[2];
    f_rise = q.fsy[1] && !q.fsy[2];
    // Data is taken on the edge opposite the one the source moves on
    smp    = q.pol[BIT_BCLK_POL] ? b_fall : b_rise;
    // Saturate so a long gap never wraps round into a short period
    bmeas  = (q.bper == 12'hFFF) ? q.bper : q.bper + 12'h001;
    fmeas  = (q.fper == 13'h1FFF) ? q.fper : q.fper + 13'h0001;
    status = 8'h00;
    status[ST_MISS]  = q.e_miss;
    status[ST_RATIO] = q.e_ratio;
    status[ST_RATE]  = q.e_rate;
    status[ST_RANGE] = q.e_range;
    status[ST_PLL]   = q.e_pll;
    status[ST_CLKER] = q.clk_err;
    status[ST_OVF]   = q.ovf;
  end

  // ==========================================================
  // Next state
  always_comb begin
    d      = q;
    d.bsy  = {q.bsy[1:0], i_bit_clock};
    d.fsy  = {q.fsy[1:0], i_frame_clock};
    d.dsy  = {q.dsy[0], i_serial_data_in};
    d.push = 1'b0;

    // Bit clock period, missing, range and PLL rate
    if (b_rise) begin
      d.bper    = 12'h000;
      d.e_range = (bmeas < 12'(BPER_MIN)) ||
                  (bmeas > 12'(BPER_MAX));
      d.e_pll   = (bmeas <= 12'(PLL_PER));
      d.e_miss  = 1'b0;
    end else begin
      if (q.bper != 12'hFFF) begin
        d.bper = bmeas;
      end
      if (q.bper >= 12'(BPER_MAX)) begin
        d.e_range = 1'b1;
      end
      if (q.bper >= 12'(BMISS)) begin
        d.e_miss = 1'b1;
        d.e_pll  = 1'b0;
      end
    end

    // Bit clocks per frame and frame period
    if (f_rise) begin
      d.e_ratio = (q.ratio < 10'(RATIO_MIN)) ||
                  (q.ratio > 10'(RATIO_MAX));
      d.e_rate  = (fmeas < 13'(FPER_MIN)) ||
                  (fmeas > 13'(P_FPER_MAX));
      d.ratio   = b_rise ? 10'h001 : 10'h000;
      d.fper    = 13'h0000;
    end else begin
      if (b_rise && q.ratio != 10'h3FF) begin
        d.ratio = q.ratio + 10'h001;
      end
      if (q.fper != 13'h1FFF) begin
        d.fper = fmeas;
      end
      if (q.ratio > 10'(RATIO_MAX)) begin
        d.e_ratio = 1'b1;
      end
      if (q.fper > 13'(P_FPER_MAX)) begin
        d.e_rate = 1'b1;
      end
    end

    d.clk_err = combine(q.mask, d.e_miss, d.e_ratio, d.e_rate,
                        d.e_range, d.e_pll);

    // Capture; once running, a word closes on every frame clock transition
    case (q.st)
      APCC_WAIT: begin
        if (smp) begin
          d.fsmp = q.fsy[2];
          d.st   = APCC_ALIGN;
        end
      end
      APCC_ALIGN: begin
        if (smp) begin
          d.shreg = {q.shreg[WORD_W-2:0], q.dsy[1]};
          if (q.fsy[2] != q.fsmp) begin
            d.shreg = {{(WORD_W-1){1'b0}}, q.dsy[1]};
            d.st    = APCC_RUN;
          end
          d.fsmp = q.fsy[2];
        end
      end
      APCC_RUN: begin
        if (smp) begin
          d.shreg = {q.shreg[WORD_W-2:0], q.dsy[1]};
          if (q.fsy[2] != q.fsmp) begin
            d.push  = 1'b1;
            d.word  = q.shreg;
            d.shreg = {{(WORD_W-1){1'b0}}, q.dsy[1]};
          end
          d.fsmp = q.fsy[2];
        end
      end
      default: begin
        d.st = APCC_WAIT;
      end
    endcase
    if (q.e_miss) begin
      d.st = APCC_WAIT;
    end

    // Output pin source
    d.sdo = q.src[BIT_OUT_SEL] ? q.dsy[1] : i_post_sdata;

    // Register port; overflow flag set wins over clear on read
    d.rdata = 8'h00;
    if (i_reg_rd) begin
      if (i_reg_addr == ADDR_MASK) begin
        d.rdata = q.mask;
      end else if (i_reg_addr == ADDR_SRC) begin
        d.rdata = q.src;
      end else if (i_reg_addr == ADDR_POL) begin
        d.rdata = q.pol;
      end else if (i_reg_addr == ADDR_STATUS) begin
        d.rdata = status;
        d.ovf   = 1'b0;
      end else begin
        d.rdata = 8'h00;
      end
    end
    if (i_reg_wr) begin
      if (i_reg_addr == ADDR_MASK) begin
        d.mask = i_reg_wdata;
      end else if (i_reg_addr == ADDR_SRC) begin
        d.src = i_reg_wdata;
      end else if (i_reg_addr == ADDR_POL) begin
        d.pol = i_reg_wdata & ~POL_RO_MSK;
      end
    end
    // A full FIFO drops the word; the loss is kept for software
    if (q.push && !fifo_ready) begin
      d.ovf = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q      <= '0;
      q.st   <= APCC_WAIT;
      q.mask <= RST_MASK;
      q.src  <= RST_SRC;
      q.pol  <= RST_POL;
    end else begin
      q <= d;
    end
  end

  apcc_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_in_valid  (q.push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (q.word),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word_data)
  );

  assign o_serial_data_out = q.sdo;
  assign o_clock_error     = q.clk_err;
  assign o_reg_rdata       = q.rdata;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_pll_flag: assert property (b_rise && bmeas <= 12'(PLL_PER)
    |=> q.e_pll)
    else $error("pll overrate not flagged");
  a_pll_ignore: assert property (q.mask[BIT_IGN_PLL] && q.e_pll &&
    !q.e_miss && !q.e_ratio && (!q.e_rate || q.mask[BIT_IGN_RATE])
    && !q.e_range && $stable(q.mask) |-> !q.clk_err)
    else $error("ignored pll error raised clock error");
  a_range_flag: assert property (b_rise && bmeas > 12'(BPER_MAX)
    |=> q.e_range)
    else $error("slow bit clock not flagged");
  a_range_use: assert property (!q.mask[BIT_IGN_RANGE] && q.e_range
    |=> q.clk_err || !q.e_range || $changed(q.mask))
    else $error("range error did not raise clock error");
  a_rate_status: assert property (i_reg_rd && i_reg_addr == ADDR_STATUS
    && q.e_rate |=> o_reg_rdata[ST_RATE])
    else $error("rate error missing from status");
  a_ratio_flag: assert property (f_rise && q.ratio < 10'(RATIO_MIN)
    |=> q.e_ratio)
    else $error("low ratio not flagged");
  a_ratio_ignore: assert property (q.mask[BIT_IGN_RATIO]
    && $stable(q.mask) && !q.e_miss && !q.e_range && !q.e_pll
    && (!q.e_rate || q.mask[BIT_IGN_RATE]) |-> !q.clk_err)
    else $error("ignored ratio error raised clock error");
  a_miss_flag: assert property (q.bper >= 12'(BMISS) && !b_rise
    && !q.mask[BIT_IGN_MISS] && $stable(q.mask)
    |=> q.e_miss ##0 q.clk_err)
    else $error("missing clock not reported");
  a_out_select: assert property (q.src[BIT_OUT_SEL] && $stable(q.src)
    |=> o_serial_data_out == $past(q.dsy[1]))
    else $error("output pin not pre data");
  a_inv_sample: assert property (q.pol[BIT_BCLK_POL] && b_rise
    |-> !smp)
    else $error("sampled on rising edge in inverted mode");
  a_reset_vals: assert property ($fell(i_srst) |-> q.mask == RST_MASK
    && q.src == RST_SRC && q.pol == RST_POL)
    else $error("control not at reset value");

  c_word_push:  cover property (q.push && fifo_ready);
  c_clk_error:  cover property ($rose(o_clock_error));
  c_fifo_full:  cover property (q.push && !fifo_ready);
  c_inverted:   cover property (q.pol[BIT_BCLK_POL] && q.push);
endmodule

/* File: apcc_src.sv */
// Behavioural serial audio source facing the clock checker.
// Assumes the bench sets run, polarity, bits per half and half period.
`timescale 1ns/1ps
module apcc_src #(
  parameter logic [31:0] P_WORD = 32'hA5C3_0F96
) (
  input  wire logic       i_run,
  input  wire logic       i_pol,
  input  wire logic [5:0] i_bits,
  input  wire logic [7:0] i_half,
  output logic            o_bclk,
  output logic            o_fclk,
  output logic            o_data
);
  // ==========================================================
  // Frame generator
  initial begin
    o_bclk = 1'b0;
    o_fclk = 1'b0;
    o_data = 1'b0;
  end

  // Half period in 0.5 ns steps; clock stands still between runs
  always begin
    wait (i_run);
    for (int b = 0; b < int'(i_bits); b++) begin
      o_bclk = i_pol;
      if (b == 0)
        o_fclk = ~o_fclk;
      o_data = P_WORD[31-b];
      #(i_half * 0.5);
      o_bclk = ~i_pol;
      #(i_half * 0.5);
    end
    // Released line must not keep looking valid
    if (!i_run)
      o_data = ~o_data;
  end
endmodule

/* File: testbench.sv */
// Self-checking bench for the audio port clock checker.
// Assumes the package, FIFO, top and source model are compiled first.
`timescale 1ns/1ps
module testbench;
  import apcc_pkg::*;

  // ==========================================================
  // Signals
  localparam logic [31:0] WORD = 32'hA5C3_0F96;
  logic              clk, srst, bclk, fclk, sdin, post, sout;
  logic              wr, rd, cerr, wvalid, wready, run, pol;
  logic [7:0]        addr, wdata, rdata, half;
  logic [5:0]        bits;
  logic [WORD_W-1:0] wdat;
  int                bad_count, num_checks, cyc, n;

  apcc_top uut (
    .i_clk_sys        (clk),
    .i_srst           (srst),
    .i_bit_clock      (bclk),
    .i_frame_clock    (fclk),
    .i_serial_data_in (sdin),
    .i_post_sdata     (post),
    .o_serial_data_out(sout),
    .i_reg_wr         (wr),
    .i_reg_rd         (rd),
    .i_reg_addr       (addr),
    .i_reg_wdata      (wdata),
    .o_reg_rdata      (rdata),
    .o_clock_error    (cerr),
    .o_word_valid     (wvalid),
    .i_word_ready     (wready),
    .o_word_data      (wdat)
  );

  apcc_src #(.P_WORD(WORD)) src (
    .i_run (run),
    .i_pol (pol),
    .i_bits(bits),
    .i_half(half),
    .o_bclk(bclk),
    .o_fclk(fclk),
    .o_data(sdin)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is about 45k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata & m, e);
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clk);
  endtask

  // Counts words taken; each must be the source pattern, MSB first
  // A word seen here is taken at the next rising edge
  task automatic drain(input int c);
    n = 0;
    wready = 1'b1;
    repeat (c) begin
      if (wvalid === 1'b1) begin
        chk(wdat, WORD);
        n++;
      end
      @(negedge clk);
    end
    wready = 1'b0;
  endtask

  task automatic restart(input logic [5:0] b, input logic [7:0] h);
    run = 1'b0;
    wait_cyc(2500);
    bits = b;
    half = h;
    run = 1'b1;
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {srst, wr, rd, post, wready, run, pol} = 7'h40;
    addr = 8'h00;
    wdata = 8'h00;
    bits = 6'd32;
    half = 8'd125;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk(cerr, 1'b0);
    rd_chk(ADDR_MASK, 8'h00, 8'hFF);
    rd_chk(ADDR_SRC, 8'h00, 8'hFF);
    rd_chk(ADDR_POL, 8'h00, 8'hFF);
    post = 1'b1;
    wait_cyc(3);
    chk(sout, 1'b1);
    wr_reg(ADDR_MASK, 8'hFF);
    rd_chk(ADDR_MASK, 8'hFF, 8'hFF);
    wr_reg(ADDR_POL, 8'hFF);
    rd_chk(ADDR_POL, 8'hF1, 8'hFF);
    wr_reg(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00, 8'hFF);
    wr_reg(ADDR_SRC, 8'h01);
    wait_cyc(5);
    chk(sout, 1'b0);
    wr_reg(ADDR_SRC, 8'h00);
    wr_reg(ADDR_POL, 8'h00);
    wr_reg(ADDR_MASK, 8'h00);
    post = 1'b0;
    // No bit clock yet: missing and range both flagged
    wait_cyc(2100);
    chk(cerr, 1'b1);
    rd_chk(ADDR_STATUS, 8'h29, 8'h29);
    wr_reg(ADDR_MASK, 8'h24);
    wait_cyc(3);
    chk(cerr, 1'b0);
    wr_reg(ADDR_MASK, 8'h00);
    // Normal polarity; consumer stalls until the FIFO overflows
    run = 1'b1;
    wait_cyc(14000);
    chk(cerr, 1'b0);
    drain(40);
    chk(32'(n >= 8), 32'h1);
    // Drained first, so no new drop can set the flag between reads
    rd_chk(ADDR_STATUS, 8'h40, 8'h7F);
    rd_chk(ADDR_STATUS, 8'h00, 8'h40);
    // Inverted polarity: wrong edge would shift every word
    // Let the running half finish before either side changes edge
    run = 1'b0;
    wait_cyc(1200);
    pol = 1'b1;
    wr_reg(ADDR_POL, 8'h20);
    restart(6'd32, 8'd125);
    wait_cyc(4000);
    drain(4000);
    chk(32'(n >= 3), 32'h1);
    // Short frames: ratio 16 and rate too fast
    restart(6'd8, 8'd125);
    wait_cyc(2500);
    chk(cerr, 1'b1);
    rd_chk(ADDR_STATUS, 8'h26, 8'h3F);
    wr_reg(ADDR_MASK, 8'h08);
    wait_cyc(3);
    chk(cerr, 1'b1);
    wr_reg(ADDR_MASK, 8'h18);
    wait_cyc(3);
    chk(cerr, 1'b0);
    rd_chk(ADDR_STATUS, 8'h06, 8'h3F);
    // Ratio of exactly 32 is legal
    bits = 6'd16;
    wait_cyc(2500);
    rd_chk(ADDR_STATUS, 8'h04, 8'h07);
    wr_reg(ADDR_MASK, 8'h10);
    wait_cyc(3);
    chk(cerr, 1'b0);
    // Six-cycle bit clock: PLL at four times that is over its limit
    restart(6'd32, 8'd24);
    wait_cyc(1500);
    rd_chk(ADDR_STATUS, 8'h34, 8'h3F);
    chk(cerr, 1'b1);
    wr_reg(ADDR_MASK, 8'h50);
    wait_cyc(3);
    chk(cerr, 1'b0);
    // Four-cycle bit clock is above the range
    restart(6'd32, 8'd16);
    wait_cyc(1500);
    chk(cerr, 1'b1);
    rd_chk(ADDR_STATUS, 8'h1C, 8'h1F);
    wr_reg(ADDR_MASK, 8'h70);
    wait_cyc(3);
    chk(cerr, 1'b0);
    wrap_up();
  end
endmodule
